// ===== omd_core_model.sv
// fetch side model: presents opcode and operand bytes
// assumes the bench loads the next bytes before each falling edge
`timescale 1ns/10ps
`default_nettype none
module omd_core_model (
	input wire logic clk,
	input wire logic [7:0] nxt_op,
	input wire logic [15:0] nxt_opd,
	output logic [7:0] opcode = 8'h00,
	output logic [15:0] operand = 16'h0000
);
	// =====================================
	// launch on falling edge, half a cycle of setup
	always @(negedge clk) begin
		opcode <= nxt_op;
		operand <= nxt_opd;
	end
endmodule // omd_core_model
`default_nettype wire

// ===== omd_decoder.sv
// opcode map decoder: one opcode byte in, registered decode out
// assumes opcode and operand come from the core fetch logic on CLK_SYS
`timescale 1ns/10ps
`default_nettype none
`include "omd_regs.svh"
module omd_decoder
	import omd_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic [7:0] OPCODE,
	input wire logic [15:0] OPERAND,
	output logic [5:0] OP_CLASS,
	output logic [4:0] ADDR_MODE,
	output logic [2:0] BIT_NUM,
	output logic [3:0] TBL_CALL_NUM,
	output logic [7:0] BR_COND,
	output logic [3:0] STK_REG,
	output logic X_POST_INC,
	output logic [15:0] UPAGE_ADDR,
	output logic [7:0] IMM_DATA,
	output logic MBIT_OK,
	output logic ILLEGAL
);
	// ==========================================================
	// field split
	logic [4:0] col;
	logic [2:0] row;
	logic mbit_in_range;
	assign col = OPCODE[`OMD_COL_MSB:`OMD_COL_LSB]; // RULE1
	assign row = OPCODE[`OMD_ROW_MSB:`OMD_ROW_LSB]; // RULE1

	omd_mbit_chk u_mbit (
		.addr(OPERAND),
		.in_range(mbit_in_range)
	);

	// ==========================================================
	// decode
	omd_op_t op_d, op_q;
	omd_mode_t mode_d, mode_q;
	logic [2:0] bit_d, bit_q;
	logic [3:0] tc_d, tc_q;
	logic [7:0] cond_d, cond_q;
	logic [3:0] stk_d, stk_q;
	logic xinc_d, xinc_q;
	logic [15:0] up_d, up_q;
	logic [7:0] imm_d, imm_q;
	logic mok_d, mok_q;
	logic ill_d, ill_q;
	omd_op_t grp;

	always_comb begin
		case (row)
		3'h0: grp = OMD_OP_ADC;
		3'h1: grp = OMD_OP_SBC;
		3'h2: grp = OMD_OP_CMP;
		3'h3: grp = OMD_OP_OR;
		3'h4: grp = OMD_OP_AND;
		3'h5: grp = OMD_OP_EOR;
		3'h6: grp = OMD_OP_LDA;
		default: grp = OMD_OP_STA;
		endcase
	end

	always_comb begin
		op_d = OMD_OP_OTHER;
		mode_d = OMD_ADR_NONE;
		bit_d = row;
		tc_d = 4'h0;
		cond_d = 8'h00;
		stk_d = 4'h0;
		xinc_d = 1'b0;
		up_d = 16'h0000;
		imm_d = OPERAND[`OMD_IMM_W-1:0]; // RULE13
		mok_d = 1'b0;
		ill_d = 1'b0;
		case (col)
		5'h00: begin
			// row 0 is the empty map slot; trap it rather than guess
			if (row == 3'h0) begin
				op_d = OMD_OP_ILLEGAL; // RULE16
				ill_d = 1'b1; // RULE16
			end
		end
		5'h01: begin
			op_d = OMD_OP_BIT_SET; // RULE4
			mode_d = OMD_ADR_DP;
		end
		5'h02, 5'h03: begin
			op_d = OMD_OP_BR_ONE; // RULE4
			mode_d = (col == 5'h02) ? OMD_ADR_ACC : OMD_ADR_DPREL;
		end
		5'h04, 5'h05, 5'h06, 5'h07: begin
			op_d = grp; // RULE2
			case (col[1:0]) // RULE2
			2'h0: mode_d = OMD_ADR_IMM;
			2'h1: mode_d = OMD_ADR_DP;
			2'h2: mode_d = OMD_ADR_DPX;
			default: mode_d = OMD_ADR_ABS;
			endcase
			if (col == 5'h04 && row == 3'h7) begin
				op_d = OMD_OP_LDM;
				mode_d = OMD_ADR_DP;
			end
		end
		5'h0a, 5'h1a: begin
			op_d = OMD_OP_TBL_CALL; // RULE7
			tc_d = {row, col[4]}; // RULE7
		end
		5'h0b: begin
			mode_d = OMD_ADR_MBIT;
			mok_d = mbit_in_range; // RULE14
		end
		5'h0d, 5'h0e: begin
			if (row <= 3'h3) begin
				op_d = (col == 5'h0d) ? OMD_OP_POP : OMD_OP_PUSH; // RULE8
				stk_d = 4'h1 << row[1:0]; // RULE8
			end else if (col == 5'h0e && row == 3'h7) begin
				op_d = OMD_OP_SWAP_AX; // RULE15
			end
		end
		5'h0f, 5'h1f: begin
			if (row == 3'h6) begin
				// decimal adjust has no datapath in this core
				op_d = OMD_OP_ILLEGAL; // RULE10
				ill_d = 1'b1; // RULE16
			end else if (row == 3'h7) begin
				op_d = (col == 5'h0f) ? OMD_OP_STOP : OMD_OP_NOP; // RULE15
			end else if (col == 5'h0f && row == 3'h0) begin
				op_d = OMD_OP_BREAK; // RULE8
			end else if (col == 5'h0f && row == 3'h2) begin
				op_d = OMD_OP_UPCALL; // RULE12
				mode_d = OMD_ADR_UPAGE;
				up_d = `OMD_UPAGE_BASE | {8'h00, OPERAND[7:0]}; // RULE12
			end
		end
		5'h10: begin
			op_d = OMD_OP_BRANCH; // RULE6
			mode_d = OMD_ADR_REL;
			cond_d = 8'h01 << row; // RULE6
		end
		5'h11: begin
			op_d = OMD_OP_BIT_CLR; // RULE5
			mode_d = OMD_ADR_DP;
		end
		5'h12, 5'h13: begin
			op_d = OMD_OP_BR_ZERO; // RULE5
			mode_d = (col == 5'h12) ? OMD_ADR_ACC : OMD_ADR_DPREL;
		end
		5'h14, 5'h15, 5'h16, 5'h17: begin
			op_d = grp; // RULE3
			case (col[1:0]) // RULE3
			2'h0: mode_d = OMD_ADR_XIND;
			2'h1: mode_d = OMD_ADR_ABSY;
			2'h2: mode_d = OMD_ADR_IDXIND;
			default: mode_d = OMD_ADR_INDY;
			endcase
		end
		5'h1b: begin
			if (row[2:1] == 2'h3) begin
				op_d = row[0] ? OMD_OP_STA : OMD_OP_LDA; // RULE11
				mode_d = OMD_ADR_XINC; // RULE11
				xinc_d = 1'b1; // RULE11
			end
		end
		5'h1d: begin
			mode_d = OMD_ADR_DP;
			case (row) // RULE9
			3'h0: op_d = OMD_OP_WADD;
			3'h1: op_d = OMD_OP_WSUB;
			3'h2: op_d = OMD_OP_WCMP;
			3'h3: op_d = OMD_OP_WLOAD;
			3'h4: op_d = OMD_OP_WINC;
			3'h5: op_d = OMD_OP_WDEC;
			3'h6: op_d = OMD_OP_WSTORE;
			default: op_d = OMD_OP_CMP_BR_NE;
			endcase
		end
		default: begin
			op_d = OMD_OP_OTHER;
		end
		endcase
	end

	// ==========================================================
	// output registers
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			op_q <= OMD_OP_OTHER;
			mode_q <= OMD_ADR_NONE;
			bit_q <= 3'h0;
			tc_q <= 4'h0;
			cond_q <= 8'h00;
			stk_q <= 4'h0;
			xinc_q <= 1'b0;
			up_q <= 16'h0000;
			imm_q <= 8'h00;
			mok_q <= 1'b0;
			ill_q <= 1'b0;
		end else begin
			op_q <= op_d;
			mode_q <= mode_d;
			bit_q <= bit_d;
			tc_q <= tc_d;
			cond_q <= cond_d;
			stk_q <= stk_d;
			xinc_q <= xinc_d;
			up_q <= up_d;
			imm_q <= imm_d;
			mok_q <= mok_d;
			ill_q <= ill_d;
		end
	end

	assign OP_CLASS = op_q;
	assign ADDR_MODE = mode_q;
	assign BIT_NUM = bit_q;
	assign TBL_CALL_NUM = tc_q;
	assign BR_COND = cond_q;
	assign STK_REG = stk_q;
	assign X_POST_INC = xinc_q;
	assign UPAGE_ADDR = up_q;
	assign IMM_DATA = imm_q;
	assign MBIT_OK = mok_q;
	assign ILLEGAL = ill_q;
endmodule // omd_decoder
`default_nettype wire

// ===== omd_decoder_properties.sv
// port checker for the opcode map decoder
// assumes a bind onto omd_decoder, single clock domain
`timescale 1ns/10ps
`default_nettype none
module omd_chk (
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic [7:0] OPCODE,
	input wire logic [15:0] OPERAND,
	input wire logic [5:0] OP_CLASS,
	input wire logic [2:0] BIT_NUM,
	input wire logic [3:0] TBL_CALL_NUM,
	input wire logic [7:0] BR_COND,
	input wire logic [3:0] STK_REG,
	input wire logic X_POST_INC,
	input wire logic [15:0] UPAGE_ADDR,
	input wire logic [7:0] IMM_DATA,
	input wire logic MBIT_OK,
	input wire logic ILLEGAL
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	// =====================================
	// decode relations, one cycle latency
	logic live_q;
	// $past is stale until one edge after reset release
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) live_q <= 1'b0;
		else live_q <= 1'b1;
	end
	bit_row_a:
		assert property (live_q |-> BIT_NUM == $past(OPCODE[7:5]))
		else $error("bit number is not the row");
	ill_code_a:
		assert property (live_q |->
			ILLEGAL == ($past(OPCODE) inside {8'h00, 8'hcf, 8'hdf}))
		else $error("illegal flag wrong");
	tbl_call_a:
		assert property (live_q && $past(OPCODE[3:0]) == 4'ha |->
			TBL_CALL_NUM == 4'(2 * $past(OPCODE[7:5]) + $past(OPCODE[4])))
		else $error("table call number wrong");
	br_cond_a:
		assert property (live_q && $past(OPCODE[4:0]) == 5'h10 |->
			BR_COND == 8'h01 << $past(OPCODE[7:5]))
		else $error("branch condition wrong");
	stk_sel_a:
		assert property (live_q && $past(OPCODE[4:2]) == 3'h3 &&
			!$past(OPCODE[7]) && $past(OPCODE[0]) != $past(OPCODE[1]) |->
			STK_REG == 4'h1 << $past(OPCODE[6:5]))
		else $error("stack register wrong");
	x_inc_a:
		assert property (live_q |->
			X_POST_INC == ($past(OPCODE) inside {8'hdb, 8'hfb}))
		else $error("post increment wrong");
	upage_addr_a:
		assert property (live_q && $past(OPCODE) == 8'h4f |->
			UPAGE_ADDR == {8'hff, $past(OPERAND[7:0])})
		else $error("upper page address wrong");
	imm_byte_a:
		assert property (live_q |-> IMM_DATA == $past(OPERAND[7:0]))
		else $error("immediate byte wrong");
	mbit_range_a:
		assert property (live_q && $past(OPCODE[4:0]) == 5'h0b |->
			MBIT_OK == ($past(OPERAND) <= 16'h0fff))
		else $error("memory bit range wrong");
endmodule // omd_chk
`default_nettype wire

// ===== omd_mbit_chk.sv
// memory bit operand range check
// assumes a 16-bit operand address from the core, same clock
`timescale 1ns/10ps
`default_nettype none
`include "omd_regs.svh"
module omd_mbit_chk (
	input wire logic [15:0] addr,
	output logic in_range
);
	always_comb begin
		in_range = (addr <= `OMD_MBIT_LIMIT); // RULE14
	end
endmodule // omd_mbit_chk
`default_nettype wire

// ===== omd_pkg.sv
// opcode map decoder types shared by the decoder and its tests
// assumes omd_regs.svh in the same folder
`default_nettype none
package omd_pkg;
typedef enum logic [4:0] {
	OMD_ADR_NONE = 5'h00, OMD_ADR_IMM = 5'h01, OMD_ADR_DP = 5'h02,
	OMD_ADR_DPX = 5'h03, OMD_ADR_ABS = 5'h04, OMD_ADR_XIND = 5'h05,
	OMD_ADR_ABSY = 5'h06, OMD_ADR_IDXIND = 5'h07, OMD_ADR_INDY = 5'h08,
	OMD_ADR_ACC = 5'h09, OMD_ADR_REL = 5'h0a, OMD_ADR_XINC = 5'h0b,
	OMD_ADR_UPAGE = 5'h0c, OMD_ADR_MBIT = 5'h0d, OMD_ADR_DPREL = 5'h0e
} omd_mode_t;
typedef enum logic [5:0] {
	OMD_OP_OTHER = 6'h00, OMD_OP_ADC = 6'h01, OMD_OP_SBC = 6'h02,
	OMD_OP_CMP = 6'h03, OMD_OP_OR = 6'h04, OMD_OP_AND = 6'h05,
	OMD_OP_EOR = 6'h06, OMD_OP_LDA = 6'h07, OMD_OP_STA = 6'h08,
	OMD_OP_BIT_SET = 6'h09, OMD_OP_BIT_CLR = 6'h0a, OMD_OP_BR_ONE = 6'h0b,
	OMD_OP_BR_ZERO = 6'h0c, OMD_OP_BRANCH = 6'h0d, OMD_OP_TBL_CALL = 6'h0e,
	OMD_OP_POP = 6'h0f, OMD_OP_PUSH = 6'h10, OMD_OP_BREAK = 6'h11,
	OMD_OP_WADD = 6'h12, OMD_OP_WSUB = 6'h13, OMD_OP_WCMP = 6'h14,
	OMD_OP_WLOAD = 6'h15, OMD_OP_WINC = 6'h16, OMD_OP_WDEC = 6'h17,
	OMD_OP_WSTORE = 6'h18, OMD_OP_CMP_BR_NE = 6'h19, OMD_OP_STOP = 6'h1a,
	OMD_OP_NOP = 6'h1b, OMD_OP_SWAP_AX = 6'h1c, OMD_OP_UPCALL = 6'h1d,
	OMD_OP_LDM = 6'h1e, OMD_OP_ILLEGAL = 6'h1f
} omd_op_t;
typedef enum logic [7:0] {
	OMD_BR_PLUS = 8'h01, OMD_BR_VCLR = 8'h02, OMD_BR_CCLR = 8'h04,
	OMD_BR_NE = 8'h08, OMD_BR_MINUS = 8'h10, OMD_BR_VSET = 8'h20,
	OMD_BR_CSET = 8'h40, OMD_BR_EQ = 8'h80
} omd_cond_t;
typedef enum logic [3:0] {
	OMD_REG_A = 4'h1, OMD_REG_X = 4'h2, OMD_REG_Y = 4'h4,
	OMD_REG_STATUS = 4'h8
} omd_stk_t;
endpackage
`default_nettype wire

// ===== omd_regs.svh
// opcode map decoder constants: opcode fields, address limits, widths
// assumes inclusion by bare name from the decoder modules, not from omd_pkg.sv
// Operation
// RULE1 - low five opcode bits are the column, upper three bits the row
// RULE2 - columns 04-07: eight alu/load/store groups, imm, dp, dp+x, abs modes; code decodes e4 as ldm, dp mode
// RULE3 - columns 14-17: same groups with {x}, abs+y, [dp+x], [dp]+y modes
// RULE4 - column 01 sets a dp bit; 02/03 branch if bit one, row is bit
// RULE5 - column 11 clears a dp bit; 12/13 branch if bit zero, row is bit
// RULE6 - column 10 rows: plus, v clear, c clear, ne, minus, v set, c set, eq
// RULE7 - columns 0a/1a table call, number twice row, plus one for 1a
// RULE8 - columns 0d/0e rows 0-3 pop/push a,x,y,status; 0f row 0 is break
// RULE9 - column 1d: word add, sub, compare, load, inc, dec, store, cmp-branch
// RULE10 - decimal adjust codes 0f/1f row 6 are never executed as valid
// RULE11 - column 1b rows 6/7 access memory at x, then increment x
// RULE12 - upper page call operand is an offset into page ff00, column 0f row 2
// RULE13 - immediate operand is one 8-bit data byte
// RULE14 - memory bit operands reach only addresses 000 to 0fff
// RULE15 - 0f row 7 stop, 1f row 7 no-operation, 0e row 7 swap acc and x
// RULE16 - opcode 00 and decimal adjust codes flag illegal
`ifndef OMD_REGS_SVH
`define OMD_REGS_SVH
`define OMD_COL_LSB 0
`define OMD_COL_MSB 4
`define OMD_ROW_LSB 5
`define OMD_ROW_MSB 7
`define OMD_UPAGE_BASE 16'hff00
`define OMD_MBIT_LIMIT 16'h0fff
`define OMD_MBIT_ADDR_W 13
`define OMD_IMM_W 8
`endif

// ===== tb_top.sv
// self-checking bench for the opcode map decoder
// assumes omd_pkg, omd_core_model and omd_chk are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import omd_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] nop = 8'h00;
	logic [15:0] nopd = 16'h0000;
	logic [7:0] op;
	logic [15:0] opd, upa;
	logic [5:0] cls;
	logic [4:0] mode;
	logic [2:0] bitn;
	logic [3:0] tnum, stk;
	logic [7:0] brc, imm;
	logic xinc, mok, ill;
	int num_errors = 0;
	int checks_done = 0;
	omd_core_model i_core (.clk(clk), .nxt_op(nop), .nxt_opd(nopd),
		.opcode(op), .operand(opd));
	omd_decoder i_dut (.CLK_SYS(clk), .ARST_N(rst_n), .OPCODE(op),
		.OPERAND(opd), .OP_CLASS(cls), .ADDR_MODE(mode), .BIT_NUM(bitn),
		.TBL_CALL_NUM(tnum), .BR_COND(brc), .STK_REG(stk),
		.X_POST_INC(xinc),
		.UPAGE_ADDR(upa), .IMM_DATA(imm), .MBIT_OK(mok), .ILLEGAL(ill));
	// =====================================
	// drive and compare
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [7:0] o, input logic [15:0] d);
		@(posedge clk);
		nop <= o;
		nopd <= d;
		@(posedge clk);
		#1;
	endtask
	task automatic t_alu;
		for (int r = 0; r < 8; r++) for (int c = 0; c < 8; c++) begin
			put({r[2:0], c[2], 2'b01, c[1:0]}, 16'h00a5);
			// e4 is the load-memory-immediate exception
			chk(cls, (r == 7 && c == 0) ? OMD_OP_LDM : 16'(r + 1));
			if (r != 7 || c != 0)
				chk(mode, 16'(c[2] ? 5 + c[1:0] : 1 + c[1:0]));
			else
				chk(mode, OMD_ADR_DP);
		end
	endtask
	task automatic t_bits;
		for (int r = 0; r < 8; r++) for (int k = 0; k < 6; k++) begin
			put({r[2:0], k > 2, 2'b00, 2'(k % 3 + 1)}, 16'h0000);
			chk(cls, k % 3 == 0 ? (k > 2 ? OMD_OP_BIT_CLR : OMD_OP_BIT_SET) :
				(k > 2 ? OMD_OP_BR_ZERO : OMD_OP_BR_ONE));
			chk(bitn, 16'(r));
			chk(mode, k % 3 == 0 ? OMD_ADR_DP : k % 3 == 1 ?
				OMD_ADR_ACC : OMD_ADR_DPREL);
		end
	endtask
	task automatic t_flow;
		for (int r = 0; r < 8; r++) begin
			put({r[2:0], 5'h10}, 16'h0000);
			chk(brc, 16'(8'h01 << r));
			chk(mode, OMD_ADR_REL);
			put({r[2:0], 5'h0a}, 16'h0000);
			chk(tnum, 16'(2 * r));
			chk(cls, OMD_OP_TBL_CALL);
			put({r[2:0], 5'h1a}, 16'h0000);
			chk(tnum, 16'(2 * r + 1));
			put({r[2:0], 5'h1d}, 16'h0000);
			chk(cls, 16'(OMD_OP_WADD + r));
			chk(mode, OMD_ADR_DP);
			if (r < 4) begin
				put({r[2:0], 5'h0d}, 16'h0000);
				chk({cls, stk}, {OMD_OP_POP, 4'(1 << r)});
				put({r[2:0], 5'h0e}, 16'h0000);
				chk({cls, stk}, {OMD_OP_PUSH, 4'(1 << r)});
			end
		end
	endtask
	task automatic t_misc;
		logic [7:0] ops [8] = '{8'h0f, 8'hef, 8'hff, 8'hee, 8'hcf, 8'hdf,
			8'h00, 8'h4f};
		logic [5:0] exp [8] = '{OMD_OP_BREAK, OMD_OP_STOP, OMD_OP_NOP,
			OMD_OP_SWAP_AX, OMD_OP_ILLEGAL, OMD_OP_ILLEGAL, OMD_OP_ILLEGAL,
			OMD_OP_UPCALL};
		for (int i = 0; i < 8; i++) begin
			put(ops[i], 16'h1234);
			chk({cls, ill}, {exp[i], i inside {4, 5, 6}});
		end
		chk(upa, 16'hff34);
		chk(mode, OMD_ADR_UPAGE);
		chk(imm, 16'h0034);
		put(8'h0b, 16'h0fff);
		chk(mok, 16'h0001);
		chk(mode, OMD_ADR_MBIT);
		put(8'h0b, 16'h1000);
		chk(mok, 16'h0000);
		put(8'hdb, 16'h0000);
		chk(xinc, 16'h0001);
		chk({cls, mode}, {OMD_OP_LDA, OMD_ADR_XINC});
		put(8'hfb, 16'h0000);
		chk(xinc, 16'h0001);
		chk({cls, mode}, {OMD_OP_STA, OMD_ADR_XINC});
		put(8'hd4, 16'h0000);
		chk(xinc, 16'h0000);
	endtask
	// mid-run reset: every output back to zero, then decode resumes
	task automatic t_reset;
		put(8'h4f, 16'h1234);
		@(negedge clk) rst_n = 1'b0;
		#1;
		chk({cls, mode, bitn, xinc, ill}, 16'h0000);
		chk({tnum, brc, stk}, 16'h0000);
		chk(upa, 16'h0000);
		chk({imm, mok}, 16'h0000);
		@(negedge clk) rst_n = 1'b1;
		@(posedge clk);
		#1;
		chk(upa, 16'hff34);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (5) @(posedge clk);
		#1;
		chk({cls, ill}, 16'h0000);
		@(negedge clk) rst_n = 1'b1;
		t_alu;
		t_bits;
		t_flow;
		t_misc;
		t_reset;
		end_of_test;
	end
	// about 340 cycles expected, allow over ten times that
	initial begin
		#(5 * 4000);
		num_errors++;
		end_of_test;
	end
endmodule // tb_top
bind omd_decoder omd_chk i_chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
	.OPCODE(OPCODE), .OPERAND(OPERAND), .OP_CLASS(OP_CLASS),
	.BIT_NUM(BIT_NUM), .TBL_CALL_NUM(TBL_CALL_NUM), .BR_COND(BR_COND),
	.STK_REG(STK_REG), .X_POST_INC(X_POST_INC), .UPAGE_ADDR(UPAGE_ADDR),
	.IMM_DATA(IMM_DATA), .MBIT_OK(MBIT_OK), .ILLEGAL(ILLEGAL));
`default_nettype wire
